//--- common/asic_consts.vh
// constants for the converter sequence and interrupt control block
`ifndef ASIC_CONSTS_VH
`define ASIC_CONSTS_VH
`define ASIC_ADDR_W          4
`define ASIC_OFS_CTRL        4'h0
`define ASIC_OFS_START       4'h1
`define ASIC_OFS_STATUS      4'h2
`define ASIC_OFS_MASK        4'h3
`define ASIC_OFS_STATE       4'h4
`define ASIC_OFS_SEQLEN      4'h5
`define ASIC_THR_HI          12
`define ASIC_THR_LO          8
`define ASIC_BIT_INTERVAL    7
`define ASIC_BIT_CONT        6
`define ASIC_BIT_IRQEN       5
`define ASIC_BIT_START       0
`define ASIC_ST_DA           0
`define ASIC_ST_EOS          1
`define ASIC_ST_CNT          2
`define ASIC_CTRL_RST        16'h0000
`define ASIC_SEQLEN_RST      5'h00
`define ASIC_CONV_TIME_NS    1000
`define ASIC_CLK_PERIOD_NS   50
`define ASIC_CONV_CYC        ((`ASIC_CONV_TIME_NS + `ASIC_CLK_PERIOD_NS - 1) / `ASIC_CLK_PERIOD_NS)
`endif

//--- src/asic_conv_timer.v
// conversion pacing timer: one done pulse per conversion time
`timescale 1ns/1ns
`default_nettype none
`include "asic_consts.vh"
module asic_conv_timer (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire       run,
    output reg        done_q
);
    // the count is reckoned in integer width, so narrow it on purpose
    localparam integer CONV_LAST_I = `ASIC_CONV_CYC - 1;
    localparam [7:0]   CONV_LAST   = CONV_LAST_I[7:0];
    reg [7:0] cnt_q;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 8'h00;
            done_q <= 1'b0;
        end else if (!run) begin
            cnt_q  <= 8'h00;
            done_q <= 1'b0;
        end else if (cnt_q == CONV_LAST) begin
            cnt_q  <= 8'h00;
            done_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 8'h01;
            done_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- src/asic_seq_ctrl.v
// converter sequence mode and data-available interrupt control
// Behaviour
// - five-bit threshold field at control bits 12:8 sets interrupt sample count
// - interval mode: interrupt after threshold plus one samples and at sequence end
// - interval select zero: data-available set only at sequence end
// - interval select bit 7 adds the threshold-plus-one sample event
// - control bit 6 one selects continuous sequences, zero single sequence
// - single mode stops conversions after the sequence's last conversion
// - clearing continuous bit stops a running continuous series at the end of the current sequence
// - interrupt request from data-available flag and its enable bit, or from status bits 2:1 through the mask
// - firmware sets start bit; single mode clears it at sequence end
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "asic_consts.vh"
module asic_seq_ctrl (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [3:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [15:0] rdata_q,
    output reg         irq_q,
    output reg         busy_q,
    output reg         sample_done_q,
    output reg         seq_end_q
);
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_CONV = 2'd1;

    reg  [15:0] ctrl_q;
    reg         conversion_start_bit_q;
    reg  [4:0]  seq_len_q;
    reg  [2:0]  status_q;
    reg  [2:0]  mask_q;
    reg  [1:0]  state_q;
    reg  [4:0]  conv_idx_q;
    reg  [4:0]  smp_cnt_q;
    wire        conv_done;

    wire [4:0] sample_count_threshold     = ctrl_q[`ASIC_THR_HI:`ASIC_THR_LO];
    wire       irq_interval_select        = ctrl_q[`ASIC_BIT_INTERVAL];
    wire       continuous_sequence_enable = ctrl_q[`ASIC_BIT_CONT];
    wire       data_available_irq_enable  = ctrl_q[`ASIC_BIT_IRQEN];
    wire       data_available_flag        = status_q[`ASIC_ST_DA];

    function is_wr;
        input [3:0] a;
        input [3:0] ofs;
        begin
            is_wr = wr_en && (a == ofs);
        end
    endfunction

    asic_conv_timer u_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (state_q == S_CONV),
        .done_q  (conv_done)
    );

    // a sequence is seq_len+1 conversions
    wire last_conv  = conv_done && (conv_idx_q == seq_len_q);
    wire thr_hit    = conv_done && ((smp_cnt_q + 5'd1) == (sample_count_threshold + 5'd1));
    wire thr_event  = irq_interval_select && thr_hit;
    // single mode ends on the last conversion; continuous keeps going
    wire seq_stop   = last_conv && !continuous_sequence_enable;
    wire start_wr   = is_wr(addr, `ASIC_OFS_START);
    wire da_event   = last_conv || thr_event;
    wire [2:0] ev   = {thr_event, last_conv, da_event};

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q    <= `ASIC_CTRL_RST;
            seq_len_q <= `ASIC_SEQLEN_RST;
            mask_q    <= 3'h0;
        end else begin
            if (is_wr(addr, `ASIC_OFS_CTRL))
                ctrl_q <= {3'h0, wdata[12:5], 5'h00};
            if (is_wr(addr, `ASIC_OFS_SEQLEN))
                seq_len_q <= wdata[4:0];
            if (is_wr(addr, `ASIC_OFS_MASK))
                mask_q <= wdata[2:0];
        end
    end

    // status bits: hardware set wins over write-one-to-clear
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= 3'h0;
        end else if (is_wr(addr, `ASIC_OFS_STATUS)) begin
            status_q <= (status_q & ~wdata[2:0]) | ev;
        end else begin
            status_q <= status_q | ev;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q                <= S_IDLE;
            conversion_start_bit_q <= 1'b0;
            conv_idx_q             <= 5'h00;
            smp_cnt_q              <= 5'h00;
        end else begin
            case (state_q)
                S_IDLE: begin
                    conv_idx_q <= 5'h00;
                    smp_cnt_q  <= 5'h00;
                    if (start_wr && wdata[`ASIC_BIT_START]) begin
                        conversion_start_bit_q <= 1'b1;
                        state_q                <= S_CONV;
                    end
                end
                S_CONV: begin
                    if (start_wr && !wdata[`ASIC_BIT_START]) begin
                        // stop on request; the running conversion is abandoned
                        conversion_start_bit_q <= 1'b0;
                        state_q                <= S_IDLE;
                    end else if (seq_stop) begin
                        conversion_start_bit_q <= 1'b0;
                        state_q                <= S_IDLE;
                    end
                    if (conv_done) begin
                        conv_idx_q <= last_conv ? 5'h00 : conv_idx_q + 5'h01;
                        if (last_conv || thr_hit)
                            smp_cnt_q <= 5'h00;
                        else
                            smp_cnt_q <= smp_cnt_q + 5'h01;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    reg [15:0] rd_mux;
    always @* begin
        case (addr)
            `ASIC_OFS_CTRL:   rd_mux = ctrl_q;
            `ASIC_OFS_START:  rd_mux = {15'h0000, conversion_start_bit_q};
            `ASIC_OFS_STATUS: rd_mux = {13'h0000, status_q};
            `ASIC_OFS_MASK:   rd_mux = {13'h0000, mask_q};
            `ASIC_OFS_STATE:  rd_mux = {1'b0, smp_cnt_q, 5'h00, conv_idx_q};
            `ASIC_OFS_SEQLEN: rd_mux = {11'h000, seq_len_q};
            default:          rd_mux = 16'h0000;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q       <= 16'h0000;
            irq_q         <= 1'b0;
            busy_q        <= 1'b0;
            sample_done_q <= 1'b0;
            seq_end_q     <= 1'b0;
        end else begin
            rdata_q       <= rd_en ? rd_mux : 16'h0000;
            // data-available needs its enable; other status bits go through the mask
            irq_q         <= (data_available_flag && data_available_irq_enable) ||
                             (|(status_q[2:1] & mask_q[2:1]));
            busy_q        <= (state_q == S_CONV);
            sample_done_q <= conv_done;
            seq_end_q     <= last_conv;
        end
    end
endmodule
`default_nettype wire

//--- verification/asic_seq_ctrl_props.sv
// checker for the converter sequence and interrupt control
`timescale 1ns/1ns
`default_nettype none
module asic_seq_ctrl_props (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [15:0] rdata_q,
    input wire logic        irq_q,
    input wire logic        busy_q,
    input wire logic        sample_done_q,
    input wire logic        seq_end_q
);
    logic [15:0] ctl_q;
    logic [2:0]  msk_q;
    logic [4:0]  cnt_q;
    wire         go_w = wr_en && addr == 4'h1;
    wire         hit_w = sample_done_q && cnt_q == ctl_q[12:8];
    wire         calm_w = !ctl_q[5] && msk_q[2:1] == 2'b00;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // shadow copies, since the checker cannot see the control register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= 16'h0000;
            msk_q <= 3'h0;
            cnt_q <= 5'h00;
        end else begin
            if (wr_en && addr == 4'h0) ctl_q <= wdata;
            if (wr_en && addr == 4'h3) msk_q <= wdata[2:0];
            // the sample counter also sits at zero whenever the sequencer is idle
            cnt_q <= (seq_end_q || hit_w || !busy_q) ? 5'h00 : cnt_q + {4'h0, sample_done_q};
        end
    end
    ctl_read_a: assert property (rd_en && addr == 4'h0 |=> rdata_q[12:5] == ctl_q[12:5])
        else $error("ctl read");
    start_busy_a: assert property (go_w && wdata[0] && !busy_q |-> ##2 busy_q)
        else $error("no start");
    stop_now_a: assert property (go_w && !wdata[0] |=> ##[0:1] !busy_q)
        else $error("no stop");
    single_stop_a: assert property (seq_end_q && !ctl_q[6] |-> ##[0:2] !busy_q)
        else $error("single ran on");
    cont_run_a: assert property (seq_end_q && ctl_q[6] && !go_w |-> ##[1:3] busy_q)
        else $error("cont halted");
    eos_irq_a: assert property (seq_end_q && ctl_q[5] |-> ##[0:2] irq_q)
        else $error("no eos irq");
    thr_irq_a: assert property (hit_w && ctl_q[7] && ctl_q[5] |-> ##[0:2] irq_q)
        else $error("no thr irq");
    irq_gate_a: assert property (calm_w && $past(calm_w) |-> !irq_q)
        else $error("irq ungated");
endmodule
bind asic_seq_ctrl asic_seq_ctrl_props asic_seq_ctrl_props_i (.*);
`default_nettype wire

//--- verification/testbench.sv
// bench for the converter sequence and interrupt control
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    wire  [15:0] rdata_q;
    wire         irq_q, busy_q, sample_done_q, seq_end_q;
    int          fail_count = 0;
    int          samples_checked = 0;
    logic [4:0]  thr;
    logic [15:0] v;
    asic_seq_ctrl asic_seq_ctrl_i (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .addr          (addr),
        .wdata         (wdata),
        .wr_en         (wr_en),
        .rd_en         (rd_en),
        .rdata_q       (rdata_q),
        .irq_q         (irq_q),
        .busy_q        (busy_q),
        .sample_done_q (sample_done_q),
        .seq_end_q     (seq_end_q)
    );
    initial forever #25 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] e, input logic [15:0] g, input string n);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        {addr, wdata, wr_en} <= {a, d, 1'b1};
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e, input string n);
        @(posedge sys_clk);
        {addr, rd_en} <= {a, 1'b1};
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 chk(e, rdata_q & m, n);
    endtask
    // negedge polling keeps pulse sampling clear of the launch edge
    task automatic wait_ev(input logic eos);
        int k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while ((eos ? !seq_end_q : !sample_done_q) && k < 3000);
        if (k >= 3000) begin
            chk(16'h0001, 16'h0000, "wait");
            give_verdict();
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #250000;
        chk(16'h0001, 16'h0000, "watchdog");
        give_verdict();
    end
    initial begin
        v = $urandom(32'hdd365a8f);
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        v = $urandom;
        wr(4'h0, v);
        rd(4'h0, 16'h1fe0, v & 16'h1fe0, "ctl");
        wr(4'he, v);
        rd(4'he, 16'hffff, 16'h0000, "unmapped");
        $display("test regs done");
        for (int iv = 0; iv < 2; iv++) begin
            thr = 5'($urandom_range(3));
            wr(4'h0, {3'h0, thr, iv[0], 7'h20});
            wr(4'h5, {11'h000, thr + 5'h02});
            wr(4'h1, 16'h0001);
            repeat (thr + 1) wait_ev(1'b0);
            rd(4'h2, 16'h0007, {13'h0, iv[0], 1'b0, iv[0]}, "thr");
            rd(4'h4, 16'h7c1f, {11'h000, thr + 5'h01}, "state");
            wait_ev(1'b1);
            repeat (3) @(negedge sys_clk);
            chk(16'h0001, {15'h0, irq_q}, "irq");
            rd(4'h2, 16'h0003, 16'h0003, "eos");
            rd(4'h1, 16'h0001, 16'h0000, "start");
            chk(16'h0000, {15'h0, busy_q}, "busy");
            wr(4'h2, 16'h0007);
            repeat (2) @(negedge sys_clk);
            chk(16'h0000, {15'h0, irq_q}, "irq clr");
        end
        $display("test interval done");
        wr(4'h0, 16'h0040);
        wr(4'h5, 16'h0001);
        wr(4'h1, 16'h0001);
        wait_ev(1'b1);
        repeat (3) @(negedge sys_clk);
        chk(16'h0001, {15'h0, busy_q}, "cont");
        chk(16'h0000, {15'h0, irq_q}, "irq off");
        wr(4'h3, 16'h0002);
        repeat (2) @(negedge sys_clk);
        chk(16'h0001, {15'h0, irq_q}, "irq mask");
        wr(4'h0, 16'h0000);
        wait_ev(1'b1);
        repeat (3) @(negedge sys_clk);
        chk(16'h0000, {15'h0, busy_q}, "single");
        wr(4'h2, 16'h0007);
        wr(4'h1, 16'h0001);
        wait_ev(1'b0);
        wr(4'h1, 16'h0000);
        repeat (2) @(negedge sys_clk);
        chk(16'h0000, {15'h0, busy_q | irq_q}, "stop");
        $display("test cont done");
        give_verdict();
    end
endmodule
`default_nettype wire
